// [octal_dac_serial_command_port_tb_top.sv]
// testbench: host and converter ends joined, checked at channel outputs and wire
`timescale 1ns/100ps
module octal_dac_serial_command_port_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_ready;
	logic echo_bit;
	logic [3:0] req_cmd = 4'h0;
	logic [11:0] req_code = 12'h000;
	logic strobe_n = 1'b1;
	logic clear_n = 1'b1;
	logic [95:0] out_code;
	logic [15:0] power_state;
	logic [7:0] active;
	logic echo_exp = 1'b0;
	logic [15:0] mon_word;
	logic [15:0] exp_word;
	logic sclk_q = 1'b1;
	logic cs_q = 1'b1;
	logic [11:0] in_m [8];
	logic [11:0] out_m [8];
	logic [1:0] pw_m [8];
	int num_errors = 0;
	int n_checks = 0;
	int seed = 21;
	odc_if link ();
	odc_host odc_host_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_cmd(req_cmd), .req_code(req_code), .load_strobe_req_n(strobe_n), .clear_req_n(clear_n),
		.echo_bit(echo_bit), .link(link));
	odc_device odc_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .out_code(out_code),
		.power_state(power_state), .active(active));
	odc_link_assertions odc_link_assertions_inst (.ref_clk(ref_clk), .rst(rst), .sclk(link.sclk), .din(link.din),
		.cs_n(link.cs_n), .load_strobe_n(link.load_strobe_n), .async_clear_n(link.async_clear_n), .dout(link.dout));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic void zero_m();
		for (int i = 0; i < 8; i++) begin
			in_m[i] = odc_pkg::CODE_RESET;
			out_m[i] = odc_pkg::CODE_RESET;
			pw_m[i] = odc_pkg::PWR_PD_100K;
		end
	endfunction
	function automatic void model(input logic [3:0] c, input logic [11:0] d);
		if (c == odc_pkg::CMD_RESET) begin
			zero_m();
		end
		for (int i = 0; i < 8; i++) begin
			logic thru;
			thru = c == odc_pkg::CMD_THRU_ALL || (c == odc_pkg::CMD_THRU_LOW && i < 4)
				|| (c == odc_pkg::CMD_THRU_HIGH && i > 3);
			if (thru || c == odc_pkg::CMD_LOAD_ALL || c == 4'(odc_pkg::CMD_LOAD_FIRST + 4'(i))) begin
				in_m[i] = d;
			end
			if (thru || (c == odc_pkg::CMD_TRANSFER && d[odc_pkg::SEL_LSB + i])) begin
				out_m[i] = in_m[i];
			end
			if (c == odc_pkg::CMD_POWER && d[odc_pkg::SEL_LSB + i]) begin
				pw_m[i] = d[3:2];
			end
		end
	endfunction
	task automatic cmp_all();
		for (int i = 0; i < 8; i++) begin
			check(16'(out_code[12*i+:12]), 16'(out_m[i]));
			check(16'(power_state[2*i+:2]), 16'(pw_m[i]));
			check(16'(active[i]), 16'(pw_m[i] == odc_pkg::PWR_UP));
		end
	endtask
	// ********
	// one word through the host, waits are bounded by the watchdog
	// ********
	task automatic send(input logic [3:0] c, input logic [11:0] d);
		while (req_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		exp_word <= {c, d};
		req_cmd <= c;
		req_code <= d;
		req_valid <= 1'b1;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		@(negedge ref_clk);
		while (req_ready !== 1'b1) @(negedge ref_clk);
		repeat (8) @(posedge ref_clk);
		// the last bit shifted in leaves the chain sixteen falls later
		echo_exp = d[0];
	endtask
	task automatic word(input logic [3:0] c, input logic [11:0] d);
		logic prev;
		prev = echo_exp;
		send(c, d);
		model(c, d);
		cmp_all();
		check(16'(echo_bit), 16'(prev));
	endtask
	always @(posedge ref_clk) begin
		sclk_q <= link.sclk;
		cs_q <= link.cs_n;
		if (sclk_q && !link.sclk && !link.cs_n) begin
			mon_word <= {mon_word[14:0], link.din};
		end
		if (!cs_q && link.cs_n && !rst) begin
			check(mon_word, exp_word);
		end
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		zero_m();
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		cmp_all();
		for (int c = 0; c < 16; c++) word(4'(c), 12'($random(seed)));
		for (int m = 0; m < 4; m++) word(odc_pkg::CMD_POWER, {8'($random(seed)), 2'(m), 2'h0});
		for (int k = 0; k < 40; k++) word(4'($random(seed)), 12'($random(seed)));
		$display("word test done");
		word(odc_pkg::CMD_LOAD_ALL, 12'($random(seed)));
		strobe_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		strobe_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		model(odc_pkg::CMD_TRANSFER, 12'hff0);
		cmp_all();
		$display("strobe test done");
		fork
			send(odc_pkg::CMD_THRU_ALL, 12'hfff);
			begin
				repeat (40) @(posedge ref_clk);
				clear_n <= 1'b0;
				repeat (6) @(posedge ref_clk);
				clear_n <= 1'b1;
			end
		join
		zero_m();
		cmp_all();
		$display("clear test done");
		word(odc_pkg::CMD_THRU_ALL, 12'h5a5);
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		zero_m();
		echo_exp = 1'b0;
		cmp_all();
		check(16'(echo_bit), 16'(echo_exp));
		$display("reset test done");
		give_verdict();
	end
endmodule

// [odc_device.sv]
// converter end: serial shift, command decode, channel registers
`timescale 1ns/100ps
module odc_device #(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial link
	odc_if.device link,
	// channel side
	output logic [CHANNELS*12-1:0] out_code,
	output logic [CHANNELS*2-1:0] power_state,
	output logic [CHANNELS-1:0] active
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] sclk_s, din_s, cs_s, ld_s, clr_s;
	logic sclk_d;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_s <= 2'h3;
			din_s <= 2'h0;
			cs_s <= 2'h3;
			ld_s <= 2'h3;
			clr_s <= 2'h3;
			sclk_d <= 1'b1;
		end else begin
			sclk_s <= {sclk_s[0], link.sclk};
			din_s <= {din_s[0], link.din};
			cs_s <= {cs_s[0], link.cs_n};
			ld_s <= {ld_s[0], link.load_strobe_n};
			clr_s <= {clr_s[0], link.async_clear_n};
			sclk_d <= sclk_s[1];
		end
	end
	logic cs_d;
	always_ff @(posedge ref_clk) begin
		if (rst)
			cs_d <= 1'b1;
		else
			cs_d <= cs_s[1];
	end
	// clear and strobe are sampled, so they act within a few ref_clk cycles, not instantly
	wire clear_on = ~clr_s[1];
	wire fall = sclk_d & ~sclk_s[1];
	wire cs_rise = ~cs_d & cs_s[1];
	// ****************************************
	// shift register and bit count
	// ****************************************
	logic [15:0] shift_reg;
	logic [4:0] count_reg;
	logic dout_reg;
	always_ff @(posedge ref_clk) begin
		if (rst || clear_on) begin
			count_reg <= 5'h00;
			shift_reg <= 16'h0000;
		end else if (cs_s[1]) begin
			count_reg <= 5'h00;
		end else if (fall) begin
			shift_reg <= {shift_reg[14:0], din_s[1]};
			if (count_reg != 5'(odc_pkg::WORD_BITS))
				count_reg <= count_reg + 5'h01;
		end
	end
	// daisy chain: the bit shifted out of the top
	always_ff @(posedge ref_clk) begin
		if (rst || clear_on)
			dout_reg <= 1'b0;
		else if (!cs_s[1] && fall)
			dout_reg <= shift_reg[15];
	end
	assign link.dout = dout_reg;
	// ****************************************
	// channel registers and command decode
	// ****************************************
	logic [11:0] in_reg [CHANNELS];
	logic [11:0] out_reg [CHANNELS];
	logic [1:0] pwr_reg [CHANNELS];
	wire [3:0] cmd = shift_reg[15:12];
	wire [11:0] code_field = shift_reg[11:0];
	wire exec = cs_rise && count_reg == 5'(odc_pkg::WORD_BITS);
	function automatic logic sel(input logic [11:0] f, input int ch);
		sel = f[odc_pkg::SEL_LSB + ch];
	endfunction
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (rst || clear_on) begin
				in_reg[i] <= odc_pkg::CODE_RESET;
				out_reg[i] <= odc_pkg::CODE_RESET;
				pwr_reg[i] <= odc_pkg::PWR_PD_100K;
			end else begin
				if (exec) begin
					case (cmd)
						odc_pkg::CMD_RESET: begin
							in_reg[i] <= odc_pkg::CODE_RESET;
							out_reg[i] <= odc_pkg::CODE_RESET;
							pwr_reg[i] <= odc_pkg::PWR_PD_100K;
						end
						odc_pkg::CMD_THRU_LOW: begin
							if (i < 4) begin
								in_reg[i] <= code_field;
								out_reg[i] <= code_field;
							end
						end
						odc_pkg::CMD_THRU_HIGH: begin
							if (i >= 4) begin
								in_reg[i] <= code_field;
								out_reg[i] <= code_field;
							end
						end
						odc_pkg::CMD_THRU_ALL: begin
							in_reg[i] <= code_field;
							out_reg[i] <= code_field;
						end
						odc_pkg::CMD_LOAD_ALL: begin
							in_reg[i] <= code_field;
						end
						odc_pkg::CMD_TRANSFER: begin
							if (sel(code_field, i))
								out_reg[i] <= in_reg[i];
						end
						odc_pkg::CMD_POWER: begin
							if (sel(code_field, i))
								pwr_reg[i] <= code_field[3:2];
						end
						odc_pkg::CMD_NOP: begin
						end
						default: begin
							if (cmd >= odc_pkg::CMD_LOAD_FIRST && cmd <= odc_pkg::CMD_LOAD_LAST
								&& int'(cmd - odc_pkg::CMD_LOAD_FIRST) == i)
								in_reg[i] <= code_field;
						end
					endcase
				end else if (!ld_s[1]) begin
					out_reg[i] <= in_reg[i];
				end
			end
		end
	end
	// ****************************************
	// channel outputs, code in straight binary
	// ****************************************
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < CHANNELS; i++) begin
			out_code[i*12 +: 12] <= out_reg[i];
			power_state[i*2 +: 2] <= pwr_reg[i];
			active[i] <= pwr_reg[i] == odc_pkg::PWR_UP;
		end
	end
endmodule

// [odc_host.sv]
// host end: frames 16-bit words onto the serial link
`timescale 1ns/100ps
module odc_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// word request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [3:0] req_cmd,
	input wire logic [11:0] req_code,
	// direct pins
	input wire logic load_strobe_req_n,
	input wire logic clear_req_n,
	output logic echo_bit,
	// serial link
	odc_if.host link
);
	// ****************************************
	// state machine
	// ****************************************
	typedef enum logic [1:0] {IDLE, SETUP, SHIFT, GAP} odc_hstate_t;
	odc_hstate_t state_reg;
	logic [15:0] word_reg;
	logic [4:0] bit_reg;
	logic [3:0] tick_reg;
	logic sclk_reg, din_reg, cs_reg, ld_reg, clr_reg;
	logic [1:0] dout_s;
	localparam logic [3:0] HALF = 4'(odc_pkg::SCLK_HALF_CYC - 1);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= IDLE;
			word_reg <= 16'h0000;
			bit_reg <= 5'h00;
			tick_reg <= 4'h0;
			sclk_reg <= 1'b1;
			din_reg <= 1'b0;
			cs_reg <= 1'b1;
		end else begin
			case (state_reg)
				IDLE: begin
					if (req_valid) begin
						word_reg <= {req_cmd, req_code};
						cs_reg <= 1'b0;
						tick_reg <= 4'(odc_pkg::SETUP_CYC);
						bit_reg <= 5'h00;
						state_reg <= SETUP;
					end
				end
				SETUP: begin
					if (tick_reg == 4'h0) begin
						din_reg <= word_reg[15];
						tick_reg <= HALF;
						state_reg <= SHIFT;
					end else
						tick_reg <= tick_reg - 4'h1;
				end
				SHIFT: begin
					// bit is set on the rising edge, stable across the fall
					if (tick_reg != 4'h0)
						tick_reg <= tick_reg - 4'h1;
					else begin
						tick_reg <= HALF;
						sclk_reg <= ~sclk_reg;
						if (sclk_reg) begin
							bit_reg <= bit_reg + 5'h01;
						end else if (bit_reg == 5'(odc_pkg::WORD_BITS)) begin
							cs_reg <= 1'b1;
							tick_reg <= 4'(odc_pkg::CS_HIGH_CYC);
							state_reg <= GAP;
						end else begin
							word_reg <= {word_reg[14:0], 1'b0};
							din_reg <= word_reg[14];
						end
					end
				end
				GAP: begin
					if (tick_reg == 4'h0)
						state_reg <= IDLE;
					else
						tick_reg <= tick_reg - 4'h1;
				end
				default: state_reg <= IDLE;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ld_reg <= 1'b1;
			clr_reg <= 1'b1;
			dout_s <= 2'h0;
		end else begin
			ld_reg <= load_strobe_req_n;
			clr_reg <= clear_req_n;
			dout_s <= {dout_s[0], link.dout};
		end
	end
	assign req_ready = state_reg == IDLE;
	assign echo_bit = dout_s[1];
	assign link.sclk = sclk_reg;
	assign link.din = din_reg;
	assign link.cs_n = cs_reg;
	assign link.load_strobe_n = ld_reg;
	assign link.async_clear_n = clr_reg;
endmodule

// [odc_if.sv]
// interface: serial command link between host and converter
`timescale 1ns/100ps
interface odc_if;
	logic sclk;
	logic din;
	logic cs_n;
	logic load_strobe_n;
	logic async_clear_n;
	logic dout;
	modport host (output sclk, output din, output cs_n, output load_strobe_n, output async_clear_n, input dout);
	modport device (input sclk, input din, input cs_n, input load_strobe_n, input async_clear_n, output dout);
endinterface

// [odc_link_assertions.sv]
// checker: wire-level assertions on the serial command link
`timescale 1ns/100ps
module odc_link_assertions (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial link
	input wire logic sclk,
	input wire logic din,
	input wire logic cs_n,
	input wire logic load_strobe_n,
	input wire logic async_clear_n,
	input wire logic dout
);
	// ********
	// falls counted within one frame
	// ********
	logic sclk_reg;
	logic [4:0] fall_cnt_reg;
	always_ff @(posedge ref_clk) begin
		sclk_reg <= sclk;
	end
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n) begin
			fall_cnt_reg <= 5'h00;
		end else if (sclk_reg && !sclk) begin
			fall_cnt_reg <= fall_cnt_reg + 5'h01;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_frame_end;
		$rose(cs_n);
	endsequence
	sequence s_low_half;
		!sclk [*3];
	endsequence
	sequence s_high_half;
		sclk [*3];
	endsequence
	// ********
	// assertions
	// ********
	a_reset_idle_pins: assert property (disable iff (1'b0) $fell(rst) |->
		cs_n && sclk && load_strobe_n && async_clear_n && !dout) else $error("link not idle after reset");
	a_sclk_idle_high: assert property (cs_n |-> sclk) else $error("serial clock moved outside a frame");
	a_din_held_fall: assert property ($fell(sclk) |-> $stable(din) ##1 $stable(din))
		else $error("data changed at serial clock fall");
	a_sclk_low_width: assert property ($fell(sclk) |=> s_low_half) else $error("serial clock low too short");
	a_sclk_high_width: assert property ($rose(sclk) |=> s_high_half) else $error("serial clock high too short");
	a_word_sixteen_bits: assert property (s_frame_end |-> fall_cnt_reg == 5'h10)
		else $error("frame not sixteen bits");
	a_cs_high_gap: assert property (s_frame_end |=> cs_n [*2]) else $error("chip select high gap too short");
	// sync stages push the update three cycles past the fall; up to one cycle past the rise is accepted
	a_dout_on_fall: assert property (($changed(dout) && async_clear_n && $past(async_clear_n, 4)) |->
		(!sclk || !$past(sclk))) else $error("data output moved away from a fall");
endmodule

// [odc_pkg.sv]
// package: shared constants for the octal converter serial command port
package odc_pkg;
	// ****************************************
	// word layout
	// ****************************************
	localparam int WORD_BITS = 16;
	localparam int CODE_BITS = 12;
	localparam int CMD_BITS = 4;
	localparam int CHANNELS = 8;
	localparam int CNT_BITS = 5;
	localparam int SEL_LSB = 4;
	// ****************************************
	// command codes
	// ****************************************
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_RESET = 4'h1;
	localparam logic [3:0] CMD_LOAD_FIRST = 4'h2;
	localparam logic [3:0] CMD_LOAD_LAST = 4'h9;
	localparam logic [3:0] CMD_THRU_LOW = 4'ha;
	localparam logic [3:0] CMD_THRU_HIGH = 4'hb;
	localparam logic [3:0] CMD_THRU_ALL = 4'hc;
	localparam logic [3:0] CMD_LOAD_ALL = 4'hd;
	localparam logic [3:0] CMD_TRANSFER = 4'he;
	localparam logic [3:0] CMD_POWER = 4'hf;
	// ****************************************
	// power states, encoded as the low data bits 3:2
	// ****************************************
	localparam logic [1:0] PWR_UP = 2'h3;
	localparam logic [1:0] PWR_HIZ = 2'h1;
	localparam logic [1:0] PWR_PD_1K = 2'h2;
	localparam logic [1:0] PWR_PD_100K = 2'h0;
	localparam logic [11:0] CODE_RESET = 12'h000;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int CS_HIGH_NS = 20;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int SCLK_MAX_KHZ = 15000;
	// half period of the generated serial clock; 4 gives 12.5 MHz, under the limit
	localparam int SCLK_HALF_CYC = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
	localparam int SETUP_CYC = 2;
endpackage
